// file: core/tui_top.sv
// Purpose: time update interrupt unit with AXI4-Lite registers and open-drain line
// Assumes: one 25 MHz clock, synchronous active-high reset, one access of each kind at a time
// Notes: line output is open-drain; drive enable is active low
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tui_top #(
	parameter int HOLD_CYCLES = tui_pkg::HOLD_CYCLES, // release interval in clocks
	parameter int SEC_CYCLES = tui_pkg::SECOND_CYCLES // clocks per second
) (
	input wire logic sys_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic s_axi_awvalid_in, // write address valid
	output logic s_axi_awready_out, // write address ready
	input wire logic [7:0] s_axi_awaddr_in, // write byte address
	input wire logic s_axi_wvalid_in, // write data valid
	output logic s_axi_wready_out, // write data ready
	input wire logic [31:0] s_axi_wdata_in, // write data
	input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
	output logic s_axi_bvalid_out, // write response valid
	input wire logic s_axi_bready_in, // write response ready
	output logic [1:0] s_axi_bresp_out, // write response
	input wire logic s_axi_arvalid_in, // read address valid
	output logic s_axi_arready_out, // read address ready
	input wire logic [7:0] s_axi_araddr_in, // read byte address
	output logic s_axi_rvalid_out, // read data valid
	input wire logic s_axi_rready_in, // read data ready
	output logic [31:0] s_axi_rdata_out, // read data
	output logic [1:0] s_axi_rresp_out, // read response
	output logic int_line_out, // open-drain data, always low
	output logic int_drive_n_out, // low while the line is pulled low
	output logic irq_out // level interrupt to the local cpu
);
	// =====================================================
	// register select decoding
	localparam int SEL_W = 3;
	localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;
	localparam logic [SEL_W-1:0] SEL_EXT = 3'h1;
	localparam logic [SEL_W-1:0] SEL_FLAG = 3'h2;
	localparam logic [SEL_W-1:0] SEL_CTRL = 3'h3;
	localparam logic [SEL_W-1:0] SEL_STAT = 3'h4;
	localparam logic [SEL_W-1:0] SEL_MASK = 3'h5;

	// maps a byte address to a register select; unaligned is unmapped
	function automatic logic [SEL_W-1:0] reg_sel(input logic [7:0] addr);
		logic [7:0] idx;
		idx = {2'h0, addr[7:2]};
		if (addr[1:0] != 2'h0) begin
			reg_sel = SEL_NONE;
		end else if (idx == tui_pkg::EXT_INDEX) begin
			reg_sel = SEL_EXT;
		end else if (idx == tui_pkg::FLAG_INDEX) begin
			reg_sel = SEL_FLAG;
		end else if (idx == tui_pkg::CTRL_INDEX) begin
			reg_sel = SEL_CTRL;
		end else if (idx == tui_pkg::IRQ_STAT_INDEX) begin
			reg_sel = SEL_STAT;
		end else if (idx == tui_pkg::IRQ_MASK_INDEX) begin
			reg_sel = SEL_MASK;
		end else begin
			reg_sel = SEL_NONE;
		end
	endfunction

	// =====================================================
	// state
	logic aw_held;
	logic [7:0] aw_addr;
	logic w_held;
	logic [7:0] w_byte;
	logic w_lane0;
	logic [7:0] ext_reg;
	logic [7:0] ctrl_reg;
	logic update_flag;
	logic line_low;
	logic [tui_pkg::HOLD_W-1:0] hold_count;
	logic [tui_pkg::IRQ_W-1:0] irq_status;
	logic [tui_pkg::IRQ_W-1:0] irq_mask;

	tui_tick_if tick ();

	tui_timebase #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_timebase (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.tick(tick)
	);

	// =====================================================
	// control fields
	wire update_period_select = ext_reg[tui_pkg::UPDATE_PERIOD_SELECT_BIT];
	wire update_irq_enable = ctrl_reg[tui_pkg::UIE_BIT];
	wire sw_reset = ctrl_reg[tui_pkg::SWRST_BIT];
	assign tick.hold = sw_reset;

	// event source: second or minute rollover, none during software reset
	wire update_event = (update_period_select ? tick.min_tick : tick.sec_tick) && !sw_reset;

	// =====================================================
	// write channel handshake
	wire do_write = aw_held && w_held && !s_axi_bvalid_out;
	wire [SEL_W-1:0] wr_sel = reg_sel(aw_addr);
	wire wr_ok = (wr_sel != SEL_NONE);
	wire wr_en = do_write && wr_ok && w_lane0;
	wire wr_ext = wr_en && (wr_sel == SEL_EXT);
	wire wr_flag = wr_en && (wr_sel == SEL_FLAG);
	wire wr_ctrl = wr_en && (wr_sel == SEL_CTRL);
	wire wr_mask = wr_en && (wr_sel == SEL_MASK);

	// a zero written at the flag position clears it; a one does nothing
	wire flag_clear = wr_flag && !w_byte[tui_pkg::UF_BIT];
	wire enable_drop = wr_ctrl && update_irq_enable && !w_byte[tui_pkg::UIE_BIT];

	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;

	// =====================================================
	// read channel handshake
	wire rd_take = s_axi_arvalid_in && s_axi_arready_out;
	wire [SEL_W-1:0] rd_sel = reg_sel(s_axi_araddr_in);
	wire rd_stat = rd_take && (rd_sel == SEL_STAT);
	assign s_axi_arready_out = !s_axi_rvalid_out;

	// read data, unused bits zero
	wire [7:0] flag_view = {2'h0, update_flag, 5'h0};
	wire [7:0] rd_byte = (rd_sel == SEL_EXT) ? ext_reg :
		(rd_sel == SEL_FLAG) ? flag_view :
		(rd_sel == SEL_CTRL) ? ctrl_reg :
		(rd_sel == SEL_STAT) ? {6'h0, irq_status} :
		(rd_sel == SEL_MASK) ? {6'h0, irq_mask} : 8'h00;

	// =====================================================
	// release timer and line state
	wire hold_done = line_low && (hold_count == tui_pkg::HOLD_W'(1));
	wire line_start = update_event && update_irq_enable;
	wire line_stop = hold_done || flag_clear || enable_drop || !update_irq_enable;

	// =====================================================
	// capture write address and data independently
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	// only the low byte lane carries register data
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata_in[7:0];
			w_lane0 <= s_axi_wstrb_in[0];
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response; unmapped addresses answer slave error
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= tui_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= wr_ok ? tui_pkg::RESP_OKAY : tui_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// read response registered one cycle after the address
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= tui_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= {24'h000000, rd_byte};
			s_axi_rresp_out <= (rd_sel != SEL_NONE) ? tui_pkg::RESP_OKAY : tui_pkg::RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// =====================================================
	// settings registers
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ext_reg <= tui_pkg::EXT_RESET;
			ctrl_reg <= tui_pkg::CTRL_RESET;
			irq_mask <= tui_pkg::IRQ_MASK_RESET;
		end else begin
			if (wr_ext) begin
				ext_reg <= w_byte;
			end
			if (wr_ctrl) begin
				ctrl_reg <= w_byte & tui_pkg::CTRL_WMASK;
			end
			if (wr_mask) begin
				irq_mask <= w_byte[tui_pkg::IRQ_W-1:0];
			end
		end
	end

	// =====================================================
	// update flag: an event in the clearing cycle wins
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			update_flag <= 1'b0;
		end else if (update_event) begin
			update_flag <= 1'b1;
		end else if (flag_clear) begin
			update_flag <= 1'b0;
		end
	end

	// =====================================================
	// line drive with restartable release counter
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			line_low <= 1'b0;
			hold_count <= '0;
		end else if (line_start && !enable_drop) begin
			line_low <= 1'b1;
			hold_count <= tui_pkg::HOLD_W'(HOLD_CYCLES);
		end else if (line_stop) begin
			line_low <= 1'b0;
			hold_count <= '0;
		end else if (line_low) begin
			hold_count <= hold_count - 1'b1;
		end
	end

	// open-drain: data always low, enable active low while pulling
	assign int_line_out = 1'b0;
	assign int_drive_n_out = !line_low;

	// =====================================================
	// local interrupt status, cleared by a read, set wins
	wire [tui_pkg::IRQ_W-1:0] irq_events = {hold_done, update_event};
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			irq_status <= '0;
		end else begin
			irq_status <= irq_events | (rd_stat ? '0 : irq_status);
		end
	end

	assign irq_out = |(irq_status & irq_mask);
endmodule

`default_nettype wire

// file: core/tui_pkg.sv
// Purpose: shared constants for the time update interrupt unit
// Assumes: 25 MHz system clock, 32-bit AXI4-Lite register access
// Notes: register byte address is four times the register index
`default_nettype none

package tui_pkg;
	// =====================================================
	// register indices and address width
	localparam logic [7:0] EXT_INDEX = 8'h0d;
	localparam logic [7:0] FLAG_INDEX = 8'h0e;
	localparam logic [7:0] CTRL_INDEX = 8'h0f;
	localparam logic [7:0] IRQ_STAT_INDEX = 8'h10;
	localparam logic [7:0] IRQ_MASK_INDEX = 8'h11;
	localparam int ADDR_W = 8;

	// =====================================================
	// field positions
	localparam int UPDATE_PERIOD_SELECT_BIT = 5;
	localparam int UF_BIT = 5;
	localparam int UIE_BIT = 5;
	localparam int SWRST_BIT = 0;
	localparam logic [7:0] FLAG_WMASK = 8'h3f;
	localparam logic [7:0] CTRL_WMASK = 8'hfd;
	localparam int IRQ_EVENT_BIT = 0;
	localparam int IRQ_RELEASE_BIT = 1;
	localparam int IRQ_W = 2;

	// =====================================================
	// reset values
	localparam logic [7:0] EXT_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

	// =====================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int SECONDS_PER_MINUTE = 60;
	localparam int HOLD_TIME_NS = 7182500;
	localparam int HOLD_CYCLES = HOLD_TIME_NS / CLK_PERIOD_NS;
	localparam int HOLD_W = 18;
	localparam int PRESCALE_W = 25;
	localparam int MINUTE_W = 6;

	// =====================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

`default_nettype wire

// file: core/tui_tick_if.sv
// Purpose: carries timekeeping ticks between the timebase and the interrupt unit
// Assumes: single clock domain
// Notes: ticks are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

interface tui_tick_if;
	logic sec_tick; // one pulse per second rollover
	logic min_tick; // one pulse per minute rollover
	logic hold; // software reset holds the timebase

	modport src (output sec_tick, output min_tick, input hold);
	modport dst (input sec_tick, input min_tick, output hold);
endinterface

`default_nettype wire

// file: core/tui_timebase.sv
// Purpose: internal timekeeping counter producing second and minute rollover ticks
// Assumes: sys_clk_in at 25 MHz, synchronous active-high reset
// Notes: held at zero while the software reset bit is set
`timescale 1ns/100ps
`default_nettype none

module tui_timebase #(
	parameter int SEC_CYCLES = tui_pkg::SECOND_CYCLES
) (
	input wire logic sys_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	tui_tick_if.src tick // ticks out, hold in
);
	logic [tui_pkg::PRESCALE_W-1:0] prescale;
	logic [tui_pkg::MINUTE_W-1:0] seconds;
	wire sec_wrap = (prescale == tui_pkg::PRESCALE_W'(SEC_CYCLES - 1));
	wire min_wrap = (seconds == tui_pkg::MINUTE_W'(tui_pkg::SECONDS_PER_MINUTE - 1));

	// =====================================================
	// second prescaler and seconds-of-minute counter
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || tick.hold) begin
			prescale <= '0;
			seconds <= '0;
		end else if (sec_wrap) begin
			prescale <= '0;
			seconds <= min_wrap ? '0 : seconds + 1'b1;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	// ticks are suppressed while held
	assign tick.sec_tick = sec_wrap && !tick.hold;
	assign tick.min_tick = sec_wrap && min_wrap && !tick.hold;
endmodule

`default_nettype wire

// file: bench/tui_top_sva.sv
// Purpose: port checker for tui_top
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every tui_top instance
`timescale 1ns/100ps
`default_nettype none

module tui_top_sva #(
	parameter int HOLD_CYCLES = 5,
	parameter int SEC_CYCLES = 20
) (
	input wire logic sys_clk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic s_axi_awvalid_in, // aw valid
	input wire logic s_axi_awready_out, // aw ready
	input wire logic [7:0] s_axi_awaddr_in, // aw address
	input wire logic s_axi_wvalid_in, // w valid
	input wire logic s_axi_wready_out, // w ready
	input wire logic [31:0] s_axi_wdata_in, // w data
	input wire logic s_axi_bvalid_out, // b valid
	input wire logic s_axi_arvalid_in, // ar valid
	input wire logic s_axi_arready_out, // ar ready
	input wire logic s_axi_rvalid_out, // r valid
	input wire logic int_line_out, // line data
	input wire logic int_drive_n_out // low while line pulled
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	int low_cnt;
	// =====================================================
	// counts samples of the line held low
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || int_drive_n_out) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end
	// bus hand-offs and clearing writes during a low line
	sequence wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence en_off_wr;
		wr_taken ##0 (!int_drive_n_out && s_axi_awaddr_in == 8'h3c && !s_axi_wdata_in[5]);
	endsequence
	sequence flag_clr_wr;
		wr_taken ##0 (!int_drive_n_out && s_axi_awaddr_in == 8'h38 && !s_axi_wdata_in[5]);
	endsequence
	line_data_a: assert property (int_line_out == 1'b0)
		else $error("line data not low");
	hold_bound_a: assert property (low_cnt <= HOLD_CYCLES)
		else $error("line low too long");
	hold_exact_a: assert property ($rose(int_drive_n_out) && !s_axi_bvalid_out |-> low_cnt == HOLD_CYCLES)
		else $error("line released early");
	enable_off_a: assert property (en_off_wr |-> ##2 int_drive_n_out)
		else $error("enable clear kept line low");
	flag_clear_a: assert property (flag_clr_wr |-> ##2 int_drive_n_out)
		else $error("flag clear kept line low");
	write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid_out)
		else $error("write response late");
	read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	read_ready_a: assert property (s_axi_arready_out == !s_axi_rvalid_out)
		else $error("arready wrong");
	write_refuse_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during response");
endmodule

bind tui_top tui_top_sva #(.HOLD_CYCLES(HOLD_CYCLES), .SEC_CYCLES(SEC_CYCLES)) sva_u (.sys_clk_in, .sys_rst_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_wdata_in, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.int_line_out, .int_drive_n_out);

`default_nettype wire

// file: bench/tui_host_model.sv
// Purpose: host view of the shared interrupt line
// Assumes: pull-up on the line
// Notes: times low periods and spacing of falls
`timescale 1ns/100ps
`default_nettype none

module tui_host_model (
	input wire logic sys_clk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic drive_n_in, // low while device drives
	input wire logic line_in, // device line data
	output logic int_n_out, // resolved line
	output var int low_len_out, // last low length
	output var int gap_out, // cycles between last falls
	output var int falls_out // falls seen
);
	int run;
	int since;
	// =====================================================
	// released line floats up through the pull-up
	assign int_n_out = drive_n_in ? 1'b1 : line_in;
	// measure low periods and fall spacing
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			run <= 0;
			since <= 0;
			falls_out <= 0;
		end else begin
			since <= since + 1;
			if (!int_n_out) run <= run + 1;
			if (int_n_out && run != 0) begin
				low_len_out <= run;
				run <= 0;
			end
			if (!int_n_out && run == 0) begin
				gap_out <= since;
				since <= 1;
				falls_out <= falls_out + 1;
			end
		end
	end
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the time update interrupt unit
// Assumes: short second and hold counts
// Notes: host model resolves the line
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam int SEC = 40;
	localparam int HOLD = 12;
	localparam logic [7:0] A_EXT = tui_pkg::EXT_INDEX << 2;
	localparam logic [7:0] A_FLG = tui_pkg::FLAG_INDEX << 2;
	localparam logic [7:0] A_CTL = tui_pkg::CTRL_INDEX << 2;
	localparam logic [7:0] A_STS = tui_pkg::IRQ_STAT_INDEX << 2;
	localparam logic [7:0] A_MSK = tui_pkg::IRQ_MASK_INDEX << 2;
	logic sys_clk_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, line, drive_n, irq, int_n;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int low_len, gap, falls, n_mismatch, n_compared;
	tui_top #(.HOLD_CYCLES(HOLD), .SEC_CYCLES(SEC)) dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.int_line_out(line), .int_drive_n_out(drive_n), .irq_out(irq));
	tui_host_model host_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .drive_n_in(drive_n),
		.line_in(line), .int_n_out(int_n), .low_len_out(low_len), .gap_out(gap), .falls_out(falls));
	// =====================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h000000, d};
		bready <= 1'b1;
		// only the watchdog ends a wait for the answer
		forever begin
			@(posedge sys_clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, 32'h0);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk_in);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		// only the watchdog ends a wait for the answer
		forever begin
			@(posedge sys_clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check($sformatf("reg %h", a), d, exp);
		check("rresp", {30'h0, r}, 32'h0);
	endtask
	task automatic wait_fall(input int lim, output int n);
		int f;
		f = falls;
		n = 0;
		while (falls == f && n < lim) begin
			@(posedge sys_clk_in);
			n++;
		end
	endtask
	task automatic wait_rel();
		int n;
		n = 0;
		while (int_n !== 1'b1 && n < 100) begin
			@(posedge sys_clk_in);
			n++;
		end
		check("line released", {31'h0, int_n}, 32'h1);
		@(posedge sys_clk_in);
	endtask
	// =====================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rdc(A_CTL, 32'h0);
		rdc(A_MSK, 32'h0);
		axi_wr(A_CTL, 8'hff);
		rdc(A_CTL, 32'hfd);
		axi_wr(A_FLG, 8'hff);
		rdc(A_FLG, 32'h0);
		axi_wr(A_EXT, 8'hff);
		rdc(A_EXT, 32'hff);
		axi_rd(8'h00, d, r);
		check("unmapped rresp", {30'h0, r}, 32'h2);
	endtask
	task automatic t_second();
		int n;
		axi_wr(A_CTL, 8'h01);
		axi_wr(A_EXT, 8'h00);
		axi_wr(A_FLG, 8'h00);
		rdc(A_STS, 32'h0);
		axi_wr(A_CTL, 8'h20);
		wait_fall(SEC + 8, n);
		check("fall", 32'(n < SEC + 8), 32'h1);
		rdc(A_FLG, 32'h20);
		check("irq masked", {31'h0, irq}, 32'h0);
		axi_wr(A_FLG, 8'hff);
		check("line kept", {31'h0, int_n}, 32'h0);
		rdc(A_FLG, 32'h20);
		wait_rel();
		check("low time", low_len, HOLD);
		rdc(A_FLG, 32'h20);
		axi_wr(A_MSK, 8'h03);
		check("irq on", {31'h0, irq}, 32'h1);
		rdc(A_STS, 32'h3);
		check("irq cleared", {31'h0, irq}, 32'h0);
		wait_fall(SEC + 8, n);
		check("gap", gap, SEC);
		axi_wr(A_FLG, 8'h00);
		check("line", {31'h0, int_n}, 32'h1);
		rdc(A_FLG, 32'h0);
		wait_rel();
		check("short low", 32'(low_len < HOLD), 32'h1);
	endtask
	task automatic t_enable_off();
		int n;
		wait_fall(SEC + 8, n);
		axi_wr(A_CTL, 8'h00);
		check("line", {31'h0, int_n}, 32'h1);
		axi_wr(A_FLG, 8'h00);
		wait_fall(SEC + 8, n);
		check("no fall", n, SEC + 8);
		rdc(A_FLG, 32'h20);
	endtask
	task automatic t_soft_reset();
		int n;
		axi_wr(A_CTL, 8'h21);
		axi_wr(A_FLG, 8'h00);
		wait_fall(3 * SEC, n);
		check("no fall", n, 3 * SEC);
		rdc(A_FLG, 32'h0);
	endtask
	task automatic t_minute();
		int n;
		axi_wr(A_CTL, 8'h01);
		axi_wr(A_EXT, 8'h20);
		axi_wr(A_CTL, 8'h20);
		wait_fall(60 * SEC + 8, n);
		check("minute fall", 32'(n < 60 * SEC + 8), 32'h1);
		wait_fall(60 * SEC + 8, n);
		check("minute fall 2", 32'(n < 60 * SEC + 8), 32'h1);
		check("minute gap", gap, 60 * SEC);
	endtask
	// mid-run reset while the line is pulled low
	task automatic t_reset();
		check("line before reset", {31'h0, int_n}, 32'h0);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		check("line after reset", {31'h0, int_n}, 32'h1);
		rdc(A_CTL, 32'h0);
		rdc(A_EXT, 32'h0);
		rdc(A_FLG, 32'h0);
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// =====================================================
	// clock, watchdog and main sequence
	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#(8000 * 40);
		n_mismatch++;
		final_report();
	end
	initial begin
		sys_rst_in = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (3) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_second();
		t_enable_off();
		t_soft_reset();
		t_minute();
		t_reset();
		final_report();
	end
endmodule

`default_nettype wire
